// file: fwg_cfg.svh
// Constants for the flash write and erase guard.
// Assumes a 20 MHz system clock and an 8-bit special register space.
`ifndef FWG_CFG_SVH
`define FWG_CFG_SVH

`define FWG_ADDR_PSC 8'h8F
`define FWG_ADDR_KEY 8'hB7
`define FWG_ADDR_STAT 8'hC0
`define FWG_ADDR_IMSK 8'hC1
`define FWG_KEY_FIRST 8'hA5
`define FWG_KEY_SECOND 8'hF1
`define FWG_ERASED_BYTE 8'hFF
`define FWG_PSC_WE_BIT 0
`define FWG_PSC_ERASE_BIT 1
`define FWG_CLK_HZ 20000000
`define FWG_WRITE_TIME_NS 57000
`define FWG_ERASE_TIME_NS 28000000
`define FWG_WRITE_CYC ((`FWG_WRITE_TIME_NS * 20 + 999) / 1000)
`define FWG_ERASE_CYC ((`FWG_ERASE_TIME_NS / 1000) * 20)
`define FWG_ST_DONE 0
`define FWG_ST_LOCKOUT 1
`define FWG_ST_FERR 2

`endif

// file: fwg_pkg.sv
// Types shared by the flash write and erase guard.
// Assumes the constants header is included beside it.
package fwg_pkg;
  typedef enum logic [1:0] {
    FWG_IDLE,
    FWG_BUSY_WR,
    FWG_BUSY_ER
  } fwg_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } fwg_xwr_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic wr;
    logic erase;
  } fwg_flash_cmd_t;
endpackage : fwg_pkg

// file: fwg_guard.sv
// Flash write and erase guard: control register, key lock, op timer, stall.
// Assumes the core holds external-data writes while stall is high.
`timescale 1ns/100ps
`include "fwg_cfg.svh"

// Behaviour
// RL1: External-data move writes carry flash address and data byte from operands.
// RL2: With write enable set, external-data move writes go to flash, not memory.
// RL3: Write enable stays set over operations until software clears it.
// RL4: Keys 0xA5 then 0xF1 unlock one operation, any delay between them.
// RL5: Wrong key or wrong order locks flash out until system reset.
// RL6: Operation attempted before unlock locks flash out until system reset.
// RL7: Every finished write or erase relocks, needing a fresh key sequence.
// RL8: Writes only clear bits; erase sets each byte to 0xFF.
// RL9: Hardware times each write and erase to completion.
// RL10: Instruction execution is stalled for the whole operation.
// RL11: Operation with supply monitor off or not a reset source causes reset.
// RL12: Firmware enables supply monitor and its reset source back to back.
// RL13: Debug-interface programming path is also accepted by the flash.
// RL14: With write enable clear, writes go to data memory, lock untouched.
module fwg_guard
  import fwg_pkg::*;
#(
  parameter int unsigned WRITE_CYC = `FWG_WRITE_CYC,
  parameter int unsigned ERASE_CYC = `FWG_ERASE_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // External-data move write from the core
  input wire logic xwr_valid_i,
  input wire fwg_xwr_t xwr_i,
  input wire logic [7:0] flash_rdata_i,
  output logic stall_o,
  output logic xram_we_o,
  output fwg_xwr_t xram_o,
  // Supply monitor status
  input wire logic vmon_en_i,
  input wire logic vmon_rst_src_i,
  // Debug interface flash path
  input wire logic dbg_valid_i,
  input wire fwg_flash_cmd_t dbg_cmd_i,
  // Flash array command
  output logic flash_strobe_o,
  output fwg_flash_cmd_t flash_cmd_o,
  output logic flash_busy_o,
  // Reset and interrupt
  output logic flash_err_rst_o,
  output logic irq_o
);

  localparam int unsigned CNT_W = $clog2(ERASE_CYC + 1);

  // The timer cannot serve a zero-length write or an erase shorter than a write
  if (WRITE_CYC < 1 || ERASE_CYC < WRITE_CYC) begin : g_bad_cyc
    $error("fwg_guard: bad operation cycle counts");
  end

  fwg_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic we_reg;
  logic erase_sel_reg;
  logic key1_reg;
  logic unlock_reg;
  logic lockout_reg;
  logic [2:0] stat_reg;
  logic [2:0] mask_reg;

  // Decode
  wire psc_wr = reg_wr_i && (reg_addr_i == `FWG_ADDR_PSC);
  wire key_wr = reg_wr_i && (reg_addr_i == `FWG_ADDR_KEY);
  wire stat_rd = reg_rd_i && (reg_addr_i == `FWG_ADDR_STAT);
  wire imsk_wr = reg_wr_i && (reg_addr_i == `FWG_ADDR_IMSK);
  wire idle = (state_reg == FWG_IDLE);
  wire key_good1 = key_wr && !key1_reg && (reg_wdata_i == `FWG_KEY_FIRST);
  wire key_good2 = key_wr && key1_reg && (reg_wdata_i == `FWG_KEY_SECOND);
  wire key_bad = key_wr && !key_good1 && !key_good2;
  wire flash_try = xwr_valid_i && we_reg && idle; // see RL2
  wire to_xram = xwr_valid_i && !we_reg; // see RL14
  wire vmon_ok = vmon_en_i && vmon_rst_src_i;
  wire op_ok = flash_try && unlock_reg && !lockout_reg && vmon_ok;
  wire op_early = flash_try && (!unlock_reg || lockout_reg); // see RL6
  wire op_ferr = flash_try && !vmon_ok; // see RL11
  wire dbg_go = dbg_valid_i && idle && !flash_try; // see RL13
  wire op_done = !idle && (cnt_reg == '0);
  // Program only clears bits: new byte is old AND requested
  wire [7:0] prog_byte = flash_rdata_i & xwr_i.data; // see RL8
  wire [7:0] dbg_prog = flash_rdata_i & dbg_cmd_i.data;
  wire [7:0] dbg_byte = dbg_cmd_i.erase ? `FWG_ERASED_BYTE : dbg_prog;
  wire [CNT_W-1:0] wr_cnt = CNT_W'(WRITE_CYC - 1);
  wire [CNT_W-1:0] er_cnt = CNT_W'(ERASE_CYC - 1);
  wire [2:0] stat_set = {op_ferr, key_bad | op_early, op_done};
  wire [2:0] stat_new = (stat_rd ? 3'h0 : stat_reg) | stat_set;
  wire [2:0] mask_new = imsk_wr ? reg_wdata_i[2:0] : mask_reg;
  wire [7:0] rd_mux =
    (reg_addr_i == `FWG_ADDR_PSC) ? {6'h00, erase_sel_reg, we_reg} :
    (reg_addr_i == `FWG_ADDR_KEY) ? {5'h00, lockout_reg, unlock_reg, key1_reg} :
    (reg_addr_i == `FWG_ADDR_STAT) ? {5'h00, stat_reg} :
    (reg_addr_i == `FWG_ADDR_IMSK) ? {5'h00, mask_reg} : 8'h00;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FWG_IDLE: begin
        if (op_ok) begin
          state_next = erase_sel_reg ? FWG_BUSY_ER : FWG_BUSY_WR;
        end else if (dbg_go) begin
          state_next = dbg_cmd_i.erase ? FWG_BUSY_ER : FWG_BUSY_WR;
        end
      end
      FWG_BUSY_WR, FWG_BUSY_ER: begin
        if (op_done) begin
          state_next = FWG_IDLE; // see RL9
        end
      end
      default: state_next = FWG_IDLE;
    endcase
  end

  // Sequencer and timer
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_reg <= FWG_IDLE;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (idle && (op_ok || dbg_go)) begin
        cnt_reg <= (op_ok ? erase_sel_reg : dbg_cmd_i.erase) ? er_cnt : wr_cnt; // see RL9
      end else if (!idle) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // Control register: cleared by software or by system reset
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      we_reg <= 1'b0;
      erase_sel_reg <= 1'b0;
    end else if (psc_wr) begin
      we_reg <= reg_wdata_i[`FWG_PSC_WE_BIT]; // see RL3
      erase_sel_reg <= reg_wdata_i[`FWG_PSC_ERASE_BIT];
    end
  end

  // Key lock; lockout is sticky until system reset
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      key1_reg <= 1'b0;
      unlock_reg <= 1'b0;
      lockout_reg <= 1'b0;
    end else begin
      if (key_bad || op_early) begin
        lockout_reg <= 1'b1; // see RL5
      end
      if (key_bad || op_early || op_ok) begin
        key1_reg <= 1'b0;
        unlock_reg <= 1'b0; // see RL7
      end else if (key_good1) begin
        key1_reg <= 1'b1; // see RL4
      end else if (key_good2) begin
        key1_reg <= 1'b0;
        unlock_reg <= 1'b1; // see RL4
      end
    end
  end

  // Status and mask; a new event wins over the read-clear
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      stat_reg <= 3'h0;
      mask_reg <= 3'h0;
      irq_o <= 1'b0;
    end else begin
      stat_reg <= stat_new;
      if (imsk_wr) begin
        mask_reg <= reg_wdata_i[2:0];
      end
      irq_o <= |(stat_new & mask_new);
    end
  end

  // Outputs
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
      stall_o <= 1'b0;
      xram_we_o <= 1'b0;
      xram_o <= '0;
      flash_strobe_o <= 1'b0;
      flash_cmd_o <= '0;
      flash_busy_o <= 1'b0;
      flash_err_rst_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
      stall_o <= (state_next != FWG_IDLE); // see RL10
      flash_busy_o <= (state_next != FWG_IDLE);
      xram_we_o <= to_xram; // see RL14
      xram_o <= xwr_i; // see RL1
      flash_err_rst_o <= op_ferr; // see RL11
      flash_strobe_o <= op_ok || dbg_go;
      if (op_ok) begin
        flash_cmd_o.addr <= xwr_i.addr; // see RL1
        flash_cmd_o.data <= erase_sel_reg ? `FWG_ERASED_BYTE : prog_byte; // see RL8
        flash_cmd_o.wr <= !erase_sel_reg;
        flash_cmd_o.erase <= erase_sel_reg;
      end else if (dbg_go) begin
        flash_cmd_o.addr <= dbg_cmd_i.addr;
        flash_cmd_o.data <= dbg_byte;
        flash_cmd_o.wr <= !dbg_cmd_i.erase;
        flash_cmd_o.erase <= dbg_cmd_i.erase;
      end
    end
  end

endmodule : fwg_guard

// file: fwg_flash_model.sv
// Flash array model: byte store that answers reads at once.
// Assumes one command per strobe from the guard.
`timescale 1ns/100ps
module fwg_flash_model
  import fwg_pkg::*;
(
  // Command side
  input wire logic clk_sys_i,
  input wire logic flash_strobe_i,
  input wire fwg_flash_cmd_t flash_cmd_i,
  // Read side
  input wire logic [15:0] rd_addr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [16];
  initial foreach (mem[i]) mem[i] = 8'hFF;
  assign rdata_o = mem[rd_addr_i[3:0]];
  // Stores what the guard sends; an array that only cleared bits would hide faults
  always @(posedge clk_sys_i) begin
    if (flash_strobe_i) mem[flash_cmd_i.addr[3:0]] <= flash_cmd_i.data;
  end
endmodule : fwg_flash_model

// file: fwg_guard_monitor.sv
// Port checker for the flash guard.
// Assumes single-cycle register and core write strobes.
`timescale 1ns/100ps
`include "fwg_cfg.svh"
module fwg_guard_monitor
  import fwg_pkg::*;
#(parameter int unsigned WRITE_CYC = 4, parameter int unsigned ERASE_CYC = 20)
(
  // Inputs
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic xwr_valid_i,
  input wire logic [7:0] flash_rdata_i,
  input wire logic vmon_en_i,
  input wire logic vmon_rst_src_i,
  // Outputs
  input wire logic stall_o,
  input wire logic xram_we_o,
  input wire logic flash_strobe_o,
  input wire fwg_flash_cmd_t flash_cmd_o,
  input wire logic flash_busy_o,
  input wire logic flash_err_rst_o,
  input wire logic irq_o
);
  logic en_reg;
  logic er_reg;
  int unsigned cnt_reg;
  wire psc_wr = reg_wr_i && reg_addr_i == `FWG_ADDR_PSC;
  wire go = xwr_valid_i && !stall_o;
  wire vm_ok = vmon_en_i && vmon_rst_src_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  always_ff @(posedge clk_sys_i) begin
    en_reg <= sys_rst_i ? 1'b0 : psc_wr ? reg_wdata_i[0] : en_reg;
    er_reg <= flash_strobe_o ? flash_cmd_o.erase : er_reg;
    cnt_reg <= stall_o ? cnt_reg + 1 : 0;
  end
  a_normal_target: assert property (go && !en_reg |=> xram_we_o && !flash_strobe_o)
    else $error("bad normal write");
  a_flash_target: assert property (go && en_reg |=> !xram_we_o)
    else $error("flash write leaked");
  a_stall_op: assert property (flash_strobe_o |-> stall_o)
    else $error("no stall");
  a_busy_level: assert property (stall_o == flash_busy_o)
    else $error("busy differs");
  a_erase_ones: assert property (
    flash_strobe_o && flash_cmd_o.erase |-> flash_cmd_o.data == 8'hFF)
    else $error("erase not ones");
  a_write_clears: assert property (flash_strobe_o && flash_cmd_o.wr
    |-> (flash_cmd_o.data & ~$past(flash_rdata_i)) == 8'h00)
    else $error("write set a bit");
  a_op_length: assert property (
    $fell(stall_o) |-> cnt_reg == (er_reg ? ERASE_CYC : WRITE_CYC))
    else $error("op length");
  a_monitor_reset: assert property (
    go && en_reg && !vm_ok |=> flash_err_rst_o && !flash_strobe_o)
    else $error("no error reset");
  c_erase: cover property (flash_strobe_o && flash_cmd_o.erase);
  c_err: cover property (flash_err_rst_o);
  c_irq: cover property (irq_o);
endmodule : fwg_guard_monitor
bind fwg_guard fwg_guard_monitor #(.WRITE_CYC(WRITE_CYC), .ERASE_CYC(ERASE_CYC))
  fwg_guard_monitor_inst (.*);

// file: fwg_guard_tb_top.sv
// Bench for the flash guard beside a flash array model.
// Assumes shortened op timings of 4 and 20 cycles.
`timescale 1ns/100ps
`include "fwg_cfg.svh"
module fwg_guard_tb_top;
  import fwg_pkg::*;
  logic clk_sys_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, rd_q = 0;
  logic xwr_valid_i = 0, dbg_valid_i = 0, vmon_en_i = 1, vmon_rst_src_i = 1;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, flash_rdata_i;
  logic stall_o, xram_we_o, flash_strobe_o, flash_busy_o, flash_err_rst_o, irq_o;
  fwg_xwr_t xwr_i = 0, xram_o;
  fwg_flash_cmd_t dbg_cmd_i = 0, flash_cmd_o;
  logic [7:0] shadow [16];
  logic [27:0] notes [$];
  int fails = 0, tests_run = 0, seed = 12;
  always #25 clk_sys_i = ~clk_sys_i;
  fwg_guard #(.WRITE_CYC(4), .ERASE_CYC(20)) fwg_guard_inst (.*);
  fwg_flash_model fwg_flash_model_inst (.clk_sys_i(clk_sys_i), .flash_strobe_i(flash_strobe_o),
    .flash_cmd_i(flash_cmd_o), .rd_addr_i(dbg_valid_i ? dbg_cmd_i.addr : xwr_i.addr),
    .rdata_o(flash_rdata_i));
  task automatic cmp(input logic [27:0] g, e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp
  task automatic rw(input logic [7:0] a, d, input logic w);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= w;
    reg_rd_i <= !w;
    if (!w) notes.push_back({12'h400, 8'h00, d});
    @(posedge clk_sys_i);
    reg_wr_i <= 0;
    reg_rd_i <= 0;
  endtask : rw
  task automatic keys(input logic [7:0] a, b);
    rw(`FWG_ADDR_KEY, a, 1);
    repeat ($unsigned($random(seed)) % 6) @(posedge clk_sys_i);
    rw(`FWG_ADDR_KEY, b, 1);
  endtask : keys
  // Kind 0 expects nothing, 1 write, 2 data memory, 3 error reset, 5 erase
  task automatic op(input logic [15:0] a, input logic [7:0] d, input logic [3:0] k, input logic dbg);
    @(posedge clk_sys_i);
    if (dbg) dbg_valid_i <= 1;
    else xwr_valid_i <= 1;
    dbg_cmd_i <= {a, d, 2'b10};
    xwr_i <= {a, d};
    if (k == 1) shadow[a[3:0]] = shadow[a[3:0]] & d;
    if (k == 5) shadow[a[3:0]] = 8'hFF;
    if (k != 0) notes.push_back({k, k == 3 ? 24'h0 : {a, k == 2 ? d : shadow[a[3:0]]}});
    @(posedge clk_sys_i);
    xwr_valid_i <= 0;
    dbg_valid_i <= 0;
    repeat (2) @(posedge clk_sys_i);
    wait (!stall_o);
  endtask : op
  task automatic rst;
    @(posedge clk_sys_i);
    sys_rst_i <= 1;
    repeat (16) @(posedge clk_sys_i);
    sys_rst_i <= 0;
  endtask : rst
  task automatic results;
    if (notes.size() != 0) fails++;
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  always @(posedge clk_sys_i) rd_q <= reg_rd_i;
  always @(negedge clk_sys_i) if (flash_strobe_o | xram_we_o | flash_err_rst_o | rd_q)
    cmp(flash_strobe_o ? {flash_cmd_o.erase ? 4'h5 : 4'h1, flash_cmd_o.addr, flash_cmd_o.data}
      : xram_we_o ? {4'h2, xram_o} : flash_err_rst_o ? 28'h3000000 : {20'h40000, reg_rdata_o},
      notes.size() ? notes.pop_front() : 28'hFFFFFFF);
  initial begin
    foreach (shadow[i]) shadow[i] = 8'hFF;
    rst();
    rw(`FWG_ADDR_STAT, 8'h00, 0);
    op(16'h0123, $random(seed), 2, 0);
    rw(`FWG_ADDR_PSC, 8'h01, 1);
    rw(`FWG_ADDR_IMSK, 8'h01, 1);
    repeat (2) begin
      keys(8'hA5, 8'hF1);
      op(16'h0007, $random(seed), 1, 0);
    end
    cmp(irq_o, 1);
    rw(`FWG_ADDR_STAT, 8'h01, 0);
    repeat (2) @(negedge clk_sys_i);
    cmp(irq_o, 0);
    rw(`FWG_ADDR_PSC, 8'h03, 1);
    keys(8'hA5, 8'hF1);
    op(16'h0007, 8'h00, 5, 0);
    rw(`FWG_ADDR_PSC, 8'h03, 0);
    op(16'h0009, 8'h3C, 1, 1);
    vmon_rst_src_i <= 0;
    keys(8'hA5, 8'hF1);
    op(16'h0002, 8'h11, 3, 0);
    vmon_rst_src_i <= 1;
    rst();
    rw(`FWG_ADDR_PSC, 8'h01, 1);
    rw(`FWG_ADDR_IMSK, 8'h02, 1);
    keys(8'hA5, 8'hF1);
    op(16'h0004, $random(seed), 1, 0);
    op(16'h0004, 8'h00, 0, 0);
    cmp(irq_o, 1);
    rw(`FWG_ADDR_STAT, 8'h03, 0);
    rst();
    rw(`FWG_ADDR_PSC, 8'h01, 1);
    keys(8'hF1, 8'hA5);
    keys(8'hA5, 8'hF1);
    op(16'h0005, 8'h00, 0, 0);
    results();
  end
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    fails++;
    results();
  end
endmodule : fwg_guard_tb_top
